// ==== common/sfdl_consts.vh ====
// Constants for the supply fault detector digital block: register map,
// field positions, reset values and glitch filter timing.
// Assumes a 100 MHz block clock and a 32-bit Wishbone register port.
`ifndef SFDL_CONSTS_VH
`define SFDL_CONSTS_VH

// Register byte offsets
`define SFDL_CH_CFG_BASE   8'h00
`define SFDL_CH_TH_BASE    8'h40
`define SFDL_STATUS        8'h80
`define SFDL_INT_STAT      8'h84
`define SFDL_INT_MASK      8'h88

// Channel config fields
`define SFDL_CFG_MODE_LSB  0
`define SFDL_CFG_RANGE_LSB 2
`define SFDL_CFG_DIG_BIT   4
`define SFDL_CFG_GF_LSB    8
`define SFDL_CFG_HYS_LSB   16
`define SFDL_CFG_WMASK     32'h001f7f1f
`define SFDL_CFG_RST       32'h00000000

// Threshold fields
`define SFDL_TH_UV_LSB     0
`define SFDL_TH_OV_LSB     8
`define SFDL_TH_RST        16'h0000

// Status and interrupt layout: detectors low, logic inputs from bit 16
`define SFDL_STAT_DIG_LSB  16

// Fault modes
`define SFDL_MODE_OFF      2'h0
`define SFDL_MODE_UV       2'h1
`define SFDL_MODE_OV       2'h2
`define SFDL_MODE_WIN      2'h3

// Input ranges
`define SFDL_RNG_LOW       2'h0
`define SFDL_RNG_MID       2'h1
`define SFDL_RNG_HIGH      2'h2
`define SFDL_RNG_VHIGH     2'h3

// Threshold code ceiling
`define SFDL_CODE_MAX      8'hff

// Glitch filter timing
`define SFDL_CLK_PERIOD_NS 10
`define SFDL_NS_PER_US     1000
`define SFDL_GF_MAX_US     7'h64
`define SFDL_GF_CYC_PER_US (`SFDL_NS_PER_US / `SFDL_CLK_PERIOD_NS)
`define SFDL_GF_CNT_W      14

`endif

// ==== hdl/sfdl_glitch_filter.v ====
// Glitch filter: one raw level in, one filtered level out.
// Assumes raw_i is already synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

module sfdl_glitch_filter #(
	parameter CNT_W = 14
) (
	// Clock and reset
	input  wire             clk_i,
	input  wire             rst_i,
	// Raw level and timeout in cycles
	input  wire             raw_i,
	input  wire [CNT_W-1:0] limit_i,
	// Filtered level
	output wire             level_o
);

	reg             level_q;
	reg [CNT_W-1:0] cnt_q;
	wire [CNT_W-1:0] cnt_inc = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};

	assign level_o = level_q;

	// Counter restarts whenever raw falls back to the committed level
	always @(posedge clk_i) begin
		if (rst_i) begin
			level_q <= 1'b0;
			cnt_q   <= {CNT_W{1'b0}};
		end else if (raw_i == level_q) begin
			cnt_q <= {CNT_W{1'b0}};
		end else if (cnt_inc >= limit_i) begin
			level_q <= raw_i;
			cnt_q   <= {CNT_W{1'b0}};
		end else begin
			cnt_q <= cnt_inc;
		end
	end

endmodule

`default_nettype wire

// ==== hdl/sfdl_top.v ====
// Digital side of a ten-channel supply fault detector bank.
// Assumes analog comparators outside, steered by the level codes driven
// here; their outputs and the logic pins are asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "sfdl_consts.vh"

module sfdl_top #(
	parameter NCH        = 10,
	parameter NDED       = 5,
	parameter NDUAL      = 5,
	parameter CYC_PER_US = `SFDL_GF_CYC_PER_US,
	parameter CNT_W      = `SFDL_GF_CNT_W
) (
	// Clock and reset
	input  wire               clk_i,
	input  wire               rst_i,
	// Wishbone slave
	input  wire               wb_cyc_i,
	input  wire               wb_stb_i,
	input  wire               wb_we_i,
	input  wire [7:0]         wb_adr_i,
	input  wire [3:0]         wb_sel_i,
	input  wire [31:0]        wb_dat_i,
	output wire [31:0]        wb_dat_o,
	output wire               wb_ack_o,
	// Comparator results and logic pins
	input  wire [NCH-1:0]     uv_cmp_i,
	input  wire [NCH-1:0]     ov_cmp_i,
	input  wire [NDUAL-1:0]   dual_function_input_i,
	// Comparator steering
	output wire [NCH*8-1:0]   uv_level_o,
	output wire [NCH*8-1:0]   ov_level_o,
	output wire [NCH*2-1:0]   range_sel_o,
	output wire [NDUAL-1:0]   warn_route_o,
	// Results
	output wire [NCH-1:0]     det_flag_o,
	output wire [NDUAL-1:0]   dig_level_o,
	output wire               irq_o
);

	// Register file
	reg [31:0]      cfg_q [0:NCH-1];
	reg [15:0]      th_q  [0:NCH-1];
	reg [NCH-1:0]   ist_det_q;
	reg [NDUAL-1:0] ist_dig_q;
	reg [NCH-1:0]   msk_det_q;
	reg [NDUAL-1:0] msk_dig_q;
	reg [31:0]      dat_q;
	reg             ack_q;
	reg             irq_q;

	// Synchronisers
	reg [NCH-1:0]   uv_s1_q;
	reg [NCH-1:0]   uv_s2_q;
	reg [NCH-1:0]   ov_s1_q;
	reg [NCH-1:0]   ov_s2_q;
	reg [NDUAL-1:0] dl_s1_q;
	reg [NDUAL-1:0] dl_s2_q;

	// Filtered and registered results
	wire [NCH-1:0]   uv_f;
	wire [NCH-1:0]   ov_f;
	wire [NDUAL-1:0] dl_f;
	reg  [NCH-1:0]   det_q;
	reg  [NDUAL-1:0] dig_q;
	wire [NCH-1:0]   det_d;
	wire [NDUAL-1:0] dig_d;
	wire [NCH*2-1:0] rng_eff;
	wire [NCH*CNT_W-1:0] lim_all;

	// Bus decode
	wire       req    = wb_cyc_i & wb_stb_i & ~ack_q;
	wire       wr     = req & wb_we_i;
	wire [5:0] widx   = wb_adr_i[7:2];
	wire [3:0] chidx  = wb_adr_i[5:2];
	wire       in_cfg = (wb_adr_i[7:6] == `SFDL_CH_CFG_BASE >> 6) && (chidx < NCH);
	wire       in_th  = (wb_adr_i[7:6] == `SFDL_CH_TH_BASE >> 6) && (chidx < NCH);

	assign wb_dat_o     = dat_q;
	assign wb_ack_o     = ack_q;
	assign irq_o        = irq_q;
	assign det_flag_o   = det_q;
	assign dig_level_o  = dig_q;

	// Byte-lane merge of a write into an old value
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  sel;
		integer b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1) begin
				if (sel[b])
					merge[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
	endfunction

	// Dual input j watches dedicated channel j+1, the last one channel 0
	function integer map_ch;
		input integer j;
		begin
			map_ch = (j == NDUAL - 1) ? 0 : j + 1;
		end
	endfunction

	// Lane-masked write data and clear pattern for status
	wire [31:0] wmrg = merge(32'h00000000, wb_dat_i, wb_sel_i);
	// Merged words for the narrow registers, cut to width at the write
	wire [31:0] th_mrg   = merge({16'h0000, th_q[chidx]}, wb_dat_i, wb_sel_i);
	wire [31:0] mskd_mrg = merge({{(32-NCH){1'b0}}, msk_det_q}, wb_dat_i, wb_sel_i);
	wire [31:0] mskg_mrg = merge({{(32-NDUAL){1'b0}}, msk_dig_q},
		wb_dat_i >> `SFDL_STAT_DIG_LSB, wb_sel_i >> 2);

	// Two-flop synchronisers for the comparator results and logic pins
	always @(posedge clk_i) begin
		if (rst_i) begin
			uv_s1_q <= {NCH{1'b0}};
			uv_s2_q <= {NCH{1'b0}};
			ov_s1_q <= {NCH{1'b0}};
			ov_s2_q <= {NCH{1'b0}};
			dl_s1_q <= {NDUAL{1'b0}};
			dl_s2_q <= {NDUAL{1'b0}};
		end else begin
			uv_s1_q <= uv_cmp_i;
			uv_s2_q <= uv_s1_q;
			ov_s1_q <= ov_cmp_i;
			ov_s2_q <= ov_s1_q;
			dl_s1_q <= dual_function_input_i;
			dl_s2_q <= dl_s1_q;
		end
	end

	genvar i;
	generate
		for (i = 0; i < NCH; i = i + 1) begin : g_ch
			wire [6:0]       gus_raw = cfg_q[i][`SFDL_CFG_GF_LSB +: 7];
			wire [6:0]       gus     = (gus_raw > `SFDL_GF_MAX_US) ? `SFDL_GF_MAX_US : gus_raw;
			wire [31:0]      prod    = gus * CYC_PER_US;
			wire [CNT_W-1:0] lim     = prod[CNT_W-1:0];
			wire [1:0]       mode    = cfg_q[i][`SFDL_CFG_MODE_LSB +: 2];
			wire [1:0]       rq      = cfg_q[i][`SFDL_CFG_RANGE_LSB +: 2];
			wire [4:0]       hys     = cfg_q[i][`SFDL_CFG_HYS_LSB +: 5];
			wire [7:0]       uv_th   = th_q[i][`SFDL_TH_UV_LSB +: 8];
			wire [7:0]       ov_th   = th_q[i][`SFDL_TH_OV_LSB +: 8];
			wire [8:0]       uv_sum  = {1'b0, uv_th} + {4'h0, hys};
			wire [7:0]       uv_hys  = uv_sum[8] ? `SFDL_CODE_MAX : uv_sum[7:0];
			wire [7:0]       ov_hys  = (ov_th > {3'h0, hys}) ? ov_th - {3'h0, hys} : 8'h00;
			reg  [7:0]       uv_lvl_q;
			reg  [7:0]       ov_lvl_q;
			reg  [1:0]       rng_q;
			reg              det_c;

			sfdl_glitch_filter #(
				.CNT_W   (CNT_W)
			) u_gf_uv (
				.clk_i   (clk_i),
				.rst_i   (rst_i),
				.raw_i   (uv_s2_q[i]),
				.limit_i (lim),
				.level_o (uv_f[i])
			);

			sfdl_glitch_filter #(
				.CNT_W   (CNT_W)
			) u_gf_ov (
				.clk_i   (clk_i),
				.rst_i   (rst_i),
				.raw_i   (ov_s2_q[i]),
				.limit_i (lim),
				.level_o (ov_f[i])
			);

			always @* begin
				case (mode)
					`SFDL_MODE_UV:  det_c = uv_f[i];
					`SFDL_MODE_OV:  det_c = ov_f[i];
					`SFDL_MODE_WIN: det_c = uv_f[i] | ov_f[i];
					default:        det_c = 1'b0;
				endcase
			end
			assign det_d[i] = det_c;
			assign lim_all[i*CNT_W +: CNT_W] = lim;

			// Allowed ranges differ per input kind
			if (i == 0) begin : g_vh
				assign rng_eff[i*2 +: 2] = (rq < `SFDL_RNG_HIGH) ? `SFDL_RNG_HIGH : rq;
			end else if (i < NDED) begin : g_vp
				assign rng_eff[i*2 +: 2] = (rq == `SFDL_RNG_VHIGH) ? `SFDL_RNG_HIGH : rq;
			end else begin : g_vx
				// Warning detector borrows the range of the input it now watches
				assign rng_eff[i*2 +: 2] = cfg_q[i][`SFDL_CFG_DIG_BIT] ?
					rng_eff[map_ch(i - NDED)*2 +: 2] : `SFDL_RNG_LOW;
			end

			// Release level moves only while the fault is held
			always @(posedge clk_i) begin
				if (rst_i) begin
					uv_lvl_q <= 8'h00;
					ov_lvl_q <= 8'h00;
					rng_q    <= `SFDL_RNG_LOW;
				end else begin
					uv_lvl_q <= uv_f[i] ? uv_hys : uv_th;
					ov_lvl_q <= ov_f[i] ? ov_hys : ov_th;
					rng_q    <= rng_eff[i*2 +: 2];
				end
			end
			assign uv_level_o[i*8 +: 8]  = uv_lvl_q;
			assign ov_level_o[i*8 +: 8]  = ov_lvl_q;
			assign range_sel_o[i*2 +: 2] = rng_q;
		end

		for (i = 0; i < NDUAL; i = i + 1) begin : g_dual
			reg route_q;

			sfdl_glitch_filter #(
				.CNT_W   (CNT_W)
			) u_gf_dig (
				.clk_i   (clk_i),
				.rst_i   (rst_i),
				.raw_i   (dl_s2_q[i]),
				.limit_i (lim_all[(NDED+i)*CNT_W +: CNT_W]),
				.level_o (dl_f[i])
			);

			// Logic level exists only while the pin is in logic mode
			assign dig_d[i] = dl_f[i] & cfg_q[NDED+i][`SFDL_CFG_DIG_BIT];

			always @(posedge clk_i) begin
				if (rst_i)
					route_q <= 1'b0;
				else
					route_q <= cfg_q[NDED+i][`SFDL_CFG_DIG_BIT];
			end
			assign warn_route_o[i] = route_q;
		end
	endgenerate

	// Results, sticky events and interrupt
	wire [NCH-1:0]   ev_det  = det_d & ~det_q;
	wire [NDUAL-1:0] ev_dig  = dig_d ^ dig_q;
	wire             ist_wr  = wr && (wb_adr_i == `SFDL_INT_STAT);
	wire [NCH-1:0]   clr_det = ist_wr ? wmrg[NCH-1:0] : {NCH{1'b0}};
	wire [NDUAL-1:0] clr_dig = ist_wr ? wmrg[`SFDL_STAT_DIG_LSB +: NDUAL] : {NDUAL{1'b0}};

	always @(posedge clk_i) begin
		if (rst_i) begin
			det_q     <= {NCH{1'b0}};
			dig_q     <= {NDUAL{1'b0}};
			ist_det_q <= {NCH{1'b0}};
			ist_dig_q <= {NDUAL{1'b0}};
			irq_q     <= 1'b0;
		end else begin
			det_q     <= det_d;
			dig_q     <= dig_d;
			// A new event beats a clear in the same cycle
			ist_det_q <= (ist_det_q & ~clr_det) | ev_det;
			ist_dig_q <= (ist_dig_q & ~clr_dig) | ev_dig;
			irq_q     <= |(ist_det_q & msk_det_q) | |(ist_dig_q & msk_dig_q);
		end
	end

	// Register writes
	integer k;
	always @(posedge clk_i) begin
		if (rst_i) begin
			for (k = 0; k < NCH; k = k + 1) begin
				cfg_q[k] <= `SFDL_CFG_RST;
				th_q[k]  <= `SFDL_TH_RST;
			end
			msk_det_q <= {NCH{1'b0}};
			msk_dig_q <= {NDUAL{1'b0}};
		end else if (wr) begin
			if (in_cfg) begin
				cfg_q[chidx] <= merge(cfg_q[chidx], wb_dat_i, wb_sel_i) & `SFDL_CFG_WMASK;
				// Logic mode is meaningless on dedicated inputs
				if (chidx < NDED)
					cfg_q[chidx][`SFDL_CFG_DIG_BIT] <= 1'b0;
			end
			if (in_th)
				th_q[chidx] <= th_mrg[15:0];
			if (wb_adr_i == `SFDL_INT_MASK) begin
				msk_det_q <= mskd_mrg[NCH-1:0];
				msk_dig_q <= mskg_mrg[NDUAL-1:0];
			end
		end
	end

	// Read mux, answered one cycle after the request is seen
	reg [31:0] rd_c;
	always @* begin
		rd_c = 32'h00000000;
		if (in_cfg)
			rd_c = cfg_q[chidx];
		else if (in_th)
			rd_c = {16'h0000, th_q[chidx]};
		else begin
			case (widx)
				`SFDL_STATUS >> 2: begin
					rd_c[NCH-1:0] = det_q;
					rd_c[`SFDL_STAT_DIG_LSB +: NDUAL] = dig_q;
				end
				`SFDL_INT_STAT >> 2: begin
					rd_c[NCH-1:0] = ist_det_q;
					rd_c[`SFDL_STAT_DIG_LSB +: NDUAL] = ist_dig_q;
				end
				`SFDL_INT_MASK >> 2: begin
					rd_c[NCH-1:0] = msk_det_q;
					rd_c[`SFDL_STAT_DIG_LSB +: NDUAL] = msk_dig_q;
				end
				default: rd_c = 32'h00000000;
			endcase
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
		end else begin
			ack_q <= req;
			if (req && !wb_we_i)
				dat_q <= rd_c;
		end
	end

endmodule

`default_nettype wire

// ==== test/sfdl_rail_model.sv ====
// Board rails as seen by the detector comparators.
// Assumes rail codes use the same 8-bit scale as the level codes.
`timescale 1ns/1ps
`default_nettype none
module sfdl_rail_model #(
	parameter NCH = 10
) (
	// Rail codes and levels
	input  wire logic [NCH*8-1:0] volt_i,
	input  wire logic [NCH*8-1:0] uv_level_i,
	input  wire logic [NCH*8-1:0] ov_level_i,
	// Comparator results
	output logic      [NCH-1:0]   uv_cmp_o,
	output logic      [NCH-1:0]   ov_cmp_o
);
	// Real comparators never pause, so neither does this
	always_comb begin
		for (int k = 0; k < NCH; k++) begin
			uv_cmp_o[k] = volt_i[k*8+:8] < uv_level_i[k*8+:8];
			ov_cmp_o[k] = volt_i[k*8+:8] > ov_level_i[k*8+:8];
		end
	end
endmodule
`default_nettype wire

// ==== test/sfdl_top_props.sv ====
// Checker for the detector top: handshake, ranges, logic filters.
// Assumes it is bound to sfdl_top and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module sfdl_top_props #(
	parameter NCH   = 10,
	parameter NDUAL = 5
) (
	input wire logic               clk_i,
	input wire logic               rst_i,
	input wire logic               wb_cyc_i,
	input wire logic               wb_stb_i,
	input wire logic               wb_we_i,
	input wire logic               wb_ack_o,
	input wire logic [31:0]        wb_dat_o,
	input wire logic [NDUAL-1:0]   dual_function_input_i,
	input wire logic [NCH*2-1:0]   range_sel_o,
	input wire logic [NDUAL-1:0]   warn_route_o,
	input wire logic [NCH-1:0]     det_flag_o,
	input wire logic [NDUAL-1:0]   dig_level_o,
	input wire logic               irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack_once;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	a_ack_follow: assert property (s_take |=> s_ack_once) else $error("ack late");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack");
	a_dat_hold: assert property (!(wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i)
		|=> $stable(wb_dat_o))
		else $error("read data moved");
	a_rst_clear: assert property ($fell(rst_i) |-> det_flag_o == 0 && dig_level_o == 0 && !irq_o)
		else $error("outputs not clear");
	a_vh_range: assert property ($past(!rst_i) |-> range_sel_o[1:0] >= 2'h2)
		else $error("high input range");
	// Duals may borrow the high input's top range; checked per dual below
	for (genvar k = 1; k < NCH - NDUAL; k++) begin : g_rng
		a_low_range: assert property (range_sel_o[2*k+:2] != 2'h3)
			else $error("range too high");
	end
	for (genvar j = 0; j < NDUAL; j++) begin : g_dual
		localparam int M = (j < 4) ? j + 1 : 0;
		a_warn_range: assert property (range_sel_o[2*(5+j)+:2] ==
			(warn_route_o[j] ? range_sel_o[2*M+:2] : 2'h0))
			else $error("dual range");
		// Pin to committed level: two sync flops, filter commit, output flop
		a_dig_filter: assert property ($changed(dig_level_o[j]) |->
			$past(dual_function_input_i[j], 4) == dig_level_o[j])
			else $error("logic level unfiltered");
		a_dig_gate: assert property (dig_level_o[j] |-> warn_route_o[j])
			else $error("analog dual shows logic");
	end
endmodule
`default_nettype wire

// ==== test/test_sfdl_top.sv ====
// Bench for the detector top: registers, fault modes, filters, interrupt.
// Assumes the rail model beside it; filters scaled to 1 cycle per us.
`timescale 1ns/1ps
`default_nettype none
module test_sfdl_top;
	logic             clk_i = 0, rst_i = 1;
	logic             wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [7:0]       wb_adr_i = 0;
	logic [3:0]       wb_sel_i = 4'hf;
	logic [31:0]      wb_dat_i = 0, wb_dat_o, q, r;
	logic             wb_ack_o, irq_o;
	logic [9:0]       uv_cmp_i, ov_cmp_i, det_flag_o;
	logic [4:0]       dual_function_input_i = 0, warn_route_o, dig_level_o;
	logic [79:0]      uv_level_o, ov_level_o, volt = {10{8'hc8}};
	logic [19:0]      range_sel_o;
	integer           num_errors = 0, comparisons = 0;
	int               vs[3] = '{50, 120, 200};
	sfdl_top #(.CYC_PER_US(1)) dut (.*);
	sfdl_rail_model #(.NCH(10)) rails (.volt_i(volt), .uv_level_i(uv_level_o),
		.ov_level_i(ov_level_o), .uv_cmp_o(uv_cmp_i), .ov_cmp_o(ov_cmp_i));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		// Only the watchdog ends a wait for ack
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		tick(1);
	endtask
	task automatic setv(input int c, input logic [7:0] x);
		@(posedge clk_i);
		volt[c*8+:8] <= x;
	endtask
	task automatic setp(input logic x);
		@(posedge clk_i);
		dual_function_input_i[0] <= x;
	endtask
	task automatic results;
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#300000;
		chk(0, 1);
		results;
	end
	initial begin
		r = $urandom(32'h554d5a66);
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		tick(1);
		r = $urandom & 32'h001f3f1c;
		wb(1, 8'h14, r);
		wb(0, 8'h14, 0);
		chk(q, r);
		wb(1, 8'h0c, 32'h10);
		wb(0, 8'h0c, 0);
		chk(q, 0);
		wb(0, 8'hfc, 0);
		chk(q, 0);
		wb(1, 8'h00, 32'h4);
		chk(range_sel_o[1:0], 2);
		$display("test regs done");
		// Undervoltage on ch1, filter of 4, hysteresis 5
		wb(1, 8'h44, 32'hff64);
		wb(1, 8'h04, 32'h0005040d);
		chk(uv_level_o[15:8], 100);
		chk(ov_level_o[15:8], 8'hff);
		chk(range_sel_o[3:2], 2);
		setv(1, 90);
		repeat (2) @(posedge clk_i);
		setv(1, 200);
		tick(12);
		chk(det_flag_o[1], 0);
		setv(1, 90);
		tick(6);
		chk(det_flag_o[1], 0);
		tick(1);
		chk(det_flag_o[1], 1);
		chk(uv_level_o[15:8], 105);
		wb(0, 8'h80, 0);
		chk(q, 2);
		wb(0, 8'h84, 0);
		chk(q, 2);
		chk(irq_o, 0);
		wb(1, 8'h88, 2);
		chk(irq_o, 1);
		wb(1, 8'h84, 2);
		chk(irq_o, 0);
		setv(1, 102);
		tick(20);
		chk(det_flag_o[1], 1);
		setv(1, 110);
		tick(20);
		chk(det_flag_o[1], 0);
		chk(uv_level_o[15:8], 100);
		$display("test undervoltage done");
		// UV, OV and window modes on ch2 against a 100..150 window
		wb(1, 8'h48, 32'h9664);
		for (int m = 1; m < 4; m++) begin
			wb(1, 8'h08, m | 8);
			foreach (vs[i]) begin
				setv(2, vs[i]);
				tick(10);
				chk(det_flag_o[2], (m[0] && vs[i] < 100) || (m[1] && vs[i] > 150));
			end
		end
		// Overvoltage held at 200; hysteresis 5 lowers the release level
		wb(1, 8'h08, 32'h0005000b);
		chk(ov_level_o[23:16], 145);
		chk(uv_level_o[23:16], 100);
		setv(2, 148);
		tick(10);
		chk(det_flag_o[2], 1);
		setv(2, 140);
		tick(10);
		chk(det_flag_o[2], 0);
		chk(ov_level_o[23:16], 150);
		$display("test modes done");
		// Dual 0 as logic input, filter of 3
		wb(1, 8'h14, 32'h310);
		chk(warn_route_o[0], 1);
		chk(range_sel_o[11:10], 2);
		setp(1);
		@(posedge clk_i);
		setp(0);
		tick(10);
		chk(dig_level_o[0], 0);
		setp(1);
		tick(5);
		chk(dig_level_o[0], 0);
		tick(1);
		chk(dig_level_o[0], 1);
		wb(0, 8'h84, 0);
		chk(q & 32'h10000, 32'h10000);
		$display("test logic input done");
		results;
	end
endmodule
bind sfdl_top sfdl_top_props #(.NCH(NCH), .NDUAL(NDUAL)) u_props (.*);
`default_nettype wire
